//--- hw/serial_line_bus_interface.sv
// Bus side, interrupt logic and serial engine of the serial line interface
//
// Operation
// - Transmitter uses baud clock; receiver may use external
// - Baud rates divided from fixed crystal reference
// - Address bits 3-12 compared to device address
// - Match captured at sync start, held during sync
// - Read strobes decoded from address bits 2:1
// - Write strobes decoded except for receiver data; none when unselected
// - Reply on any strobe or vector gating
// - Interrupt enables load from data bit 6
// - Receive enable and data available raise request
// - Transmit enable and buffer empty raise request
// - Acknowledge gates vector, replies, drops request
// - Receive request served before transmit request
// - Acknowledge passed on when not requesting
// - Stored acknowledge cleared by idle acknowledge
// - Initialize clears control, keeps data registers
// - Receiver status read: modem, available, enable
// - Transmitter status read: empty, enable, break
// - Receiver data on low byte, drivers on input
// - Break holds serial output at space
// - Reader run drops eight receive ticks (half a bit) after start
`timescale 1ns/1ps
module serial_line_bus_interface
  import serial_line_pkg::*;
#(
  parameter logic [9:0] DEV_ADDR = 10'h200,
  parameter logic [15:0] VECTOR = 16'h0040,
  parameter logic [2:0] BAUD_SEL = 3'h0,
  parameter bit EXT_RX_CLK = 1'b0,
  parameter int DATA_BITS = 8,
  parameter bit PARITY_EN = 1'b0,
  parameter bit PARITY_ODD = 1'b0,
  parameter int STOP_BITS = 1
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Backplane bus, low-active strobes
  input wire logic BUS_SYNC_STROBE_N,
  input wire logic BUS_DATA_IN_STROBE_N,
  input wire logic BUS_DATA_OUT_STROBE_N,
  input wire logic IO_PAGE_SELECT_N,
  input wire logic ACK_CHAIN_IN_N,
  input wire logic BUS_INITIALIZE_N,
  input wire logic [15:0] BUS_ADDR_DATA_LINES_IN,
  output logic [15:0] BUS_ADDR_DATA_LINES_OUT,
  output logic BUS_ADDR_DATA_LINES_OE,
  output logic BUS_REPLY_N,
  output logic BUS_INT_REQUEST_N,
  output logic ACK_CHAIN_OUT_N,
  // Serial line
  input wire logic SERIAL_IN,
  input wire logic EXT_RX_CLOCK,
  input wire logic MODEM_STATUS,
  output logic SERIAL_OUT,
  output logic READER_RUN
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  pins_t pin_raw, pin_meta_reg, pin_reg;
  logic [15:0] dal_meta_reg, dal_reg;
  logic sync_prev_reg, iak_prev_reg, xclk_prev_reg;
  assign pin_raw = '{sync: ~BUS_SYNC_STROBE_N, din: ~BUS_DATA_IN_STROBE_N,
    dout: ~BUS_DATA_OUT_STROBE_N, io_page: ~IO_PAGE_SELECT_N, ack_in: ~ACK_CHAIN_IN_N,
    init: ~BUS_INITIALIZE_N, serial_in: SERIAL_IN, ext_rx_clk: EXT_RX_CLOCK, modem: MODEM_STATUS};
  always_ff @(posedge CLK) begin
    pin_meta_reg <= pin_raw;
    pin_reg <= pin_meta_reg;
    dal_meta_reg <= BUS_ADDR_DATA_LINES_IN;
    dal_reg <= dal_meta_reg;
    sync_prev_reg <= pin_reg.sync;
    iak_prev_reg <= pin_reg.ack_in;
    xclk_prev_reg <= pin_reg.ext_rx_clk;
  end
  // ------------------------------------------------------------
  // Baud generator
  // ------------------------------------------------------------
  // Fractional accumulator stands in for the crystal; jitter is one CLK
  logic [ACC_W-1:0] acc_reg, acc_next, acc_sum;
  logic [10:0] div_reg, div_next;
  logic xtal_tick, tx_tick, rx_tick;
  always_comb begin
    acc_sum = acc_reg + ACC_W'(XTAL_HZ);
    xtal_tick = acc_sum >= ACC_W'(CLK_HZ);
    acc_next = xtal_tick ? acc_sum - ACC_W'(CLK_HZ) : acc_sum;
    div_next = div_reg;
    tx_tick = 1'b0;
    if (xtal_tick) begin
      if (div_reg == baud_divisor(BAUD_SEL) - 11'h001) begin
        div_next = '0;
        tx_tick = 1'b1;
      end else begin
        div_next = div_reg + 11'h001;
      end
    end
    rx_tick = EXT_RX_CLK ? (pin_reg.ext_rx_clk & ~xclk_prev_reg) : tx_tick;
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      acc_reg <= '0;
      div_reg <= '0;
    end else begin
      acc_reg <= acc_next;
      div_reg <= div_next;
    end
  end
  // ------------------------------------------------------------
  // Function decoding
  // ------------------------------------------------------------
  logic match_reg, match_next;
  logic [1:0] func_reg, func_next;
  strobes_t strobe, strobe_prev_reg;
  logic sync_rise;
  always_comb begin
    sync_rise = pin_reg.sync & ~sync_prev_reg;
    match_next = match_reg;
    func_next = func_reg;
    if (sync_rise) begin
      match_next = pin_reg.io_page && dal_reg[12:3] == DEV_ADDR;
      func_next = dal_reg[2:1];
    end else if (!pin_reg.sync) begin
      match_next = 1'b0;
    end
    strobe = '0;
    if (match_reg && pin_reg.din) begin
      unique case (func_reg)
        FN_RX_STATUS: strobe.rd_rs = 1'b1;
        FN_RX_DATA: strobe.rd_rd = 1'b1;
        FN_TX_STATUS: strobe.rd_ts = 1'b1;
        FN_TX_DATA: strobe.rd_td = 1'b1;
      endcase
    end else if (match_reg && pin_reg.dout) begin
      unique case (func_reg)
        FN_RX_STATUS: strobe.wr_rs = 1'b1;
        FN_RX_DATA: strobe.wr_rs = 1'b0;
        FN_TX_STATUS: strobe.wr_ts = 1'b1;
        FN_TX_DATA: strobe.wr_td = 1'b1;
      endcase
    end
  end
  // ------------------------------------------------------------
  // Control, interrupts and bus answers
  // ------------------------------------------------------------
  logic rx_ie_reg, rx_ie_next, tx_ie_reg, tx_ie_next, brk_reg, brk_next;
  logic da_reg, da_next, tbmt_reg, tbmt_next;
  logic rx_req_reg, rx_req_next, tx_req_reg, tx_req_next;
  logic rx_cond_reg, tx_cond_reg, rx_cond, tx_cond;
  logic vec_reg, vec_next, vec_rx_reg, vec_rx_next, ack_st_reg, ack_st_next;
  logic ack_out_reg, ack_out_next, rr_reg, rr_next, rr_go_reg, rr_go_next;
  logic [3:0] rr_cnt_reg, rr_cnt_next;
  logic [7:0] rx_data_reg, rx_data_next, tx_data_reg, tx_data_next;
  logic [15:0] dal_out_next;
  logic dal_oe_next, iak_rise, rx_done, rx_start_seen, tx_take;
  logic [7:0] rx_byte;
  always_comb begin
    rx_ie_next = rx_ie_reg;
    tx_ie_next = tx_ie_reg;
    brk_next = brk_reg;
    da_next = da_reg;
    tbmt_next = tbmt_reg;
    rx_data_next = rx_data_reg;
    tx_data_next = tx_data_reg;
    rr_next = rr_reg;
    rr_go_next = rr_go_reg;
    rr_cnt_next = rr_cnt_reg;
    if (strobe.wr_rs && !strobe_prev_reg.wr_rs) begin
      rx_ie_next = dal_reg[BIT_IE];
      if (dal_reg[BIT_READER]) begin
        rr_next = 1'b1;
        rr_go_next = 1'b0;
        rr_cnt_next = '0;
      end
    end
    if (strobe.wr_ts && !strobe_prev_reg.wr_ts) begin
      tx_ie_next = dal_reg[BIT_IE];
      brk_next = dal_reg[BIT_BREAK];
    end
    if (strobe.wr_td && !strobe_prev_reg.wr_td) begin
      tx_data_next = dal_reg[7:0];
      tbmt_next = 1'b0;
    end
    if (tx_take) tbmt_next = 1'b1;
    if (strobe.rd_rd && !strobe_prev_reg.rd_rd) da_next = 1'b0;
    // Set wins over the clearing read
    if (rx_done) begin
      da_next = 1'b1;
      rx_data_next = rx_byte;
    end
    if (rr_reg && rx_start_seen) rr_go_next = 1'b1;
    if (rr_go_reg && rx_tick) begin
      rr_cnt_next = rr_cnt_reg + 4'h1;
      if (rr_cnt_reg == HALF_BIT_LAST) begin
        rr_next = 1'b0;
        rr_go_next = 1'b0;
      end
    end
    // Requests arm on a rising condition so an acknowledge can drop them
    rx_cond = rx_ie_reg & da_reg;
    tx_cond = tx_ie_reg & tbmt_reg;
    rx_req_next = rx_cond & (rx_req_reg | ~rx_cond_reg);
    tx_req_next = tx_cond & (tx_req_reg | ~tx_cond_reg);
    vec_next = vec_reg;
    vec_rx_next = vec_rx_reg;
    ack_st_next = ack_st_reg;
    ack_out_next = ack_out_reg;
    iak_rise = pin_reg.ack_in & ~iak_prev_reg;
    if (iak_rise) begin
      if (rx_req_reg || tx_req_reg) begin
        vec_next = 1'b1;
        vec_rx_next = rx_req_reg;
        ack_st_next = 1'b1;
        if (rx_req_reg) rx_req_next = 1'b0;
        else tx_req_next = 1'b0;
      end else begin
        ack_out_next = 1'b1;
        ack_st_next = 1'b0;
      end
    end
    if (!pin_reg.ack_in) begin
      vec_next = 1'b0;
      ack_out_next = 1'b0;
    end
    if (pin_reg.init) begin
      rx_ie_next = 1'b0;
      tx_ie_next = 1'b0;
      brk_next = 1'b0;
      rx_req_next = 1'b0;
      tx_req_next = 1'b0;
      ack_st_next = 1'b0;
      rr_next = 1'b0;
      rr_go_next = 1'b0;
      da_next = 1'b0;
      tbmt_next = RESET_TBMT;
    end
    dal_out_next = '0;
    if (strobe.rd_rs) begin
      dal_out_next[BIT_MODEM] = pin_reg.modem;
      dal_out_next[BIT_READY] = da_reg;
      dal_out_next[BIT_IE] = rx_ie_reg;
    end else if (strobe.rd_ts) begin
      dal_out_next[BIT_READY] = tbmt_reg;
      dal_out_next[BIT_IE] = tx_ie_reg;
      dal_out_next[BIT_BREAK] = brk_reg;
    end else if (strobe.rd_rd) begin
      dal_out_next[7:0] = rx_data_reg;
    end else if (vec_next) begin
      dal_out_next = vec_rx_next ? VECTOR : VECTOR + VEC_TX_STEP;
    end
    dal_oe_next = pin_reg.din && (strobe.rd_rs || strobe.rd_rd || strobe.rd_ts || strobe.rd_td || vec_next);
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      match_reg <= 1'b0;
      func_reg <= '0;
      strobe_prev_reg <= '0;
      rx_ie_reg <= 1'b0;
      tx_ie_reg <= 1'b0;
      brk_reg <= 1'b0;
      da_reg <= 1'b0;
      tbmt_reg <= RESET_TBMT;
      rx_req_reg <= 1'b0;
      tx_req_reg <= 1'b0;
      rx_cond_reg <= 1'b0;
      tx_cond_reg <= 1'b0;
      vec_reg <= 1'b0;
      vec_rx_reg <= 1'b0;
      ack_st_reg <= 1'b0;
      ack_out_reg <= 1'b0;
      rr_reg <= 1'b0;
      rr_go_reg <= 1'b0;
      rr_cnt_reg <= '0;
      rx_data_reg <= '0;
      tx_data_reg <= '0;
      BUS_ADDR_DATA_LINES_OUT <= '0;
      BUS_ADDR_DATA_LINES_OE <= 1'b0;
      BUS_REPLY_N <= RESET_PIN_N;
      BUS_INT_REQUEST_N <= RESET_PIN_N;
      ACK_CHAIN_OUT_N <= RESET_PIN_N;
      READER_RUN <= 1'b0;
    end else begin
      match_reg <= match_next;
      func_reg <= func_next;
      strobe_prev_reg <= strobe;
      rx_ie_reg <= rx_ie_next;
      tx_ie_reg <= tx_ie_next;
      brk_reg <= brk_next;
      da_reg <= da_next;
      tbmt_reg <= tbmt_next;
      rx_req_reg <= rx_req_next;
      tx_req_reg <= tx_req_next;
      rx_cond_reg <= rx_cond;
      tx_cond_reg <= tx_cond;
      vec_reg <= vec_next;
      vec_rx_reg <= vec_rx_next;
      ack_st_reg <= ack_st_next;
      ack_out_reg <= ack_out_next;
      rr_reg <= rr_next;
      rr_go_reg <= rr_go_next;
      rr_cnt_reg <= rr_cnt_next;
      rx_data_reg <= rx_data_next;
      tx_data_reg <= tx_data_next;
      BUS_ADDR_DATA_LINES_OUT <= dal_out_next;
      BUS_ADDR_DATA_LINES_OE <= dal_oe_next;
      BUS_REPLY_N <= ~((|strobe) | vec_next);
      BUS_INT_REQUEST_N <= ~(rx_req_next | tx_req_next);
      ACK_CHAIN_OUT_N <= ~ack_out_next;
      READER_RUN <= rr_next;
    end
  end
  // ------------------------------------------------------------
  // Serial transmitter and receiver
  // ------------------------------------------------------------
  tx_state_t tx_st_reg, tx_st_next;
  rx_state_t rx_st_reg, rx_st_next;
  logic [3:0] tx_cnt_reg, tx_cnt_next, rx_cnt_reg, rx_cnt_next;
  logic [2:0] tx_bit_reg, tx_bit_next, rx_bit_reg, rx_bit_next;
  logic [7:0] tx_sh_reg, tx_sh_next, rx_sh_reg, rx_sh_next;
  logic tx_par_reg, tx_par_next, line_next, tx_end, rx_mid;
  always_comb begin
    tx_st_next = tx_st_reg;
    tx_bit_next = tx_bit_reg;
    tx_sh_next = tx_sh_reg;
    tx_par_next = tx_par_reg;
    tx_cnt_next = tx_tick ? tx_cnt_reg + 4'h1 : tx_cnt_reg;
    tx_end = tx_tick && tx_cnt_reg == OVERSAMPLE_LAST;
    tx_take = tx_st_reg == TX_IDLE && !tbmt_reg && tx_tick;
    unique case (tx_st_reg)
      TX_IDLE: if (tx_take) begin
        tx_st_next = TX_START;
        tx_sh_next = tx_data_reg;
        tx_par_next = PARITY_ODD;
        tx_cnt_next = '0;
      end
      TX_START: if (tx_end) begin
        tx_st_next = TX_DATA;
        tx_bit_next = '0;
      end
      TX_DATA: if (tx_end) begin
        tx_par_next = tx_par_reg ^ tx_sh_reg[0];
        tx_sh_next = tx_sh_reg >> 1;
        tx_bit_next = tx_bit_reg + 3'h1;
        if (tx_bit_reg == 3'(DATA_BITS - 1)) begin
          tx_st_next = PARITY_EN ? TX_PARITY : TX_STOP;
          tx_bit_next = '0;
        end
      end
      TX_PARITY: if (tx_end) tx_st_next = TX_STOP;
      TX_STOP: if (tx_end) begin
        tx_bit_next = tx_bit_reg + 3'h1;
        if (tx_bit_reg == 3'(STOP_BITS - 1)) tx_st_next = TX_IDLE;
      end
      default: tx_st_next = TX_IDLE;
    endcase
    unique case (tx_st_next)
      TX_START: line_next = 1'b0;
      TX_DATA: line_next = tx_sh_next[0];
      TX_PARITY: line_next = tx_par_next;
      default: line_next = RESET_LINE;
    endcase
    if (brk_next) line_next = 1'b0;
    rx_st_next = rx_st_reg;
    rx_bit_next = rx_bit_reg;
    rx_sh_next = rx_sh_reg;
    rx_cnt_next = rx_tick ? rx_cnt_reg + 4'h1 : rx_cnt_reg;
    rx_mid = rx_tick && rx_cnt_reg == OVERSAMPLE_LAST;
    rx_start_seen = 1'b0;
    rx_done = 1'b0;
    rx_byte = rx_sh_reg >> (8 - DATA_BITS);
    unique case (rx_st_reg)
      RX_IDLE: if (rx_tick && !pin_reg.serial_in) begin
        rx_st_next = RX_START;
        rx_cnt_next = '0;
        rx_start_seen = 1'b1;
      end
      RX_START: if (rx_tick && rx_cnt_reg == HALF_BIT_LAST) begin
        rx_st_next = pin_reg.serial_in ? RX_IDLE : RX_DATA;
        rx_cnt_next = '0;
        rx_bit_next = '0;
      end
      RX_DATA: if (rx_mid) begin
        rx_sh_next = {pin_reg.serial_in, rx_sh_reg[7:1]};
        rx_bit_next = rx_bit_reg + 3'h1;
        if (rx_bit_reg == 3'(DATA_BITS - 1)) rx_st_next = PARITY_EN ? RX_PARITY : RX_STOP;
      end
      RX_PARITY: if (rx_mid) rx_st_next = RX_STOP;
      RX_STOP: if (rx_mid) begin
        rx_st_next = RX_IDLE;
        rx_done = 1'b1;
      end
      default: rx_st_next = RX_IDLE;
    endcase
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      tx_st_reg <= TX_IDLE;
      rx_st_reg <= RX_IDLE;
      tx_cnt_reg <= '0;
      rx_cnt_reg <= '0;
      tx_bit_reg <= '0;
      rx_bit_reg <= '0;
      tx_sh_reg <= '0;
      rx_sh_reg <= '0;
      tx_par_reg <= 1'b0;
      SERIAL_OUT <= RESET_LINE;
    end else begin
      tx_st_reg <= tx_st_next;
      rx_st_reg <= rx_st_next;
      tx_cnt_reg <= tx_cnt_next;
      rx_cnt_reg <= rx_cnt_next;
      tx_bit_reg <= tx_bit_next;
      rx_bit_reg <= rx_bit_next;
      tx_sh_reg <= tx_sh_next;
      rx_sh_reg <= rx_sh_next;
      tx_par_reg <= tx_par_next;
      SERIAL_OUT <= line_next;
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_unselected_quiet: assert property (!match_reg && !vec_next |=> BUS_REPLY_N)
    else $error("reply while unselected");
  a_match_holds: assert property (match_reg && pin_reg.sync |=> match_reg || sync_rise)
    else $error("match dropped during sync");
  a_reply_on_read: assert property (strobe.rd_rs |=> !BUS_REPLY_N && BUS_ADDR_DATA_LINES_OE)
    else $error("no reply to status read");
  a_rx_ie_load: assert property (strobe.wr_rs && !strobe_prev_reg.wr_rs && !pin_reg.init
    |=> rx_ie_reg == $past(dal_reg[BIT_IE]))
    else $error("receive enable not loaded");
  a_init_clears: assert property (pin_reg.init |=> !rx_ie_reg && !brk_reg && !da_reg && tbmt_reg && BUS_INT_REQUEST_N)
    else $error("initialize left control state");
  a_rx_first: assert property (iak_rise && rx_req_reg && tx_req_reg
    |=> vec_reg && BUS_ADDR_DATA_LINES_OUT == VECTOR ##0 !rx_req_reg)
    else $error("receive request not served first");
  a_ack_pass: assert property (iak_rise && !rx_req_reg && !tx_req_reg |=> !ACK_CHAIN_OUT_N && !vec_reg)
    else $error("acknowledge not passed on");
  a_ack_clear: assert property (iak_rise && !pin_reg.init |=> ack_st_reg == $past(rx_req_reg || tx_req_reg))
    else $error("stored acknowledge wrong");
  a_break_space: assert property (brk_reg |-> !SERIAL_OUT)
    else $error("break not holding space");
  a_reader_stop: assert property (rr_go_reg && rx_tick && rr_cnt_reg == HALF_BIT_LAST && !rx_start_seen
    |=> !READER_RUN)
    else $error("reader run not negated");
endmodule : serial_line_bus_interface

//--- hw/serial_line_pkg.sv
// Shared constants, carrier types and helpers for the serial line bus interface
package serial_line_pkg;
  // ------------------------------------------------------------
  // Clocking and serial timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int XTAL_HZ = 2_457_600;
  localparam int ACC_W = 27;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] HALF_BIT_LAST = 4'h7;
  // ------------------------------------------------------------
  // Register function codes and bit positions
  // ------------------------------------------------------------
  localparam logic [1:0] FN_RX_STATUS = 2'h0;
  localparam logic [1:0] FN_RX_DATA = 2'h1;
  localparam logic [1:0] FN_TX_STATUS = 2'h2;
  localparam logic [1:0] FN_TX_DATA = 2'h3;
  localparam int BIT_MODEM = 15;
  localparam int BIT_READY = 7;
  localparam int BIT_IE = 6;
  localparam int BIT_BREAK = 0;
  localparam int BIT_READER = 0;
  localparam logic [15:0] VEC_TX_STEP = 16'h0004;
  // ------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------
  localparam logic RESET_TBMT = 1'b1;
  localparam logic RESET_PIN_N = 1'b1;
  localparam logic RESET_LINE = 1'b1;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic sync;
    logic din;
    logic dout;
    logic io_page;
    logic ack_in;
    logic init;
    logic serial_in;
    logic ext_rx_clk;
    logic modem;
  } pins_t;
  typedef struct packed {
    logic rd_rs;
    logic rd_rd;
    logic rd_ts;
    logic rd_td;
    logic wr_rs;
    logic wr_ts;
    logic wr_td;
  } strobes_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010, TX_PARITY = 3'b011, TX_STOP = 3'b100
  } tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010, RX_PARITY = 3'b011, RX_STOP = 3'b100
  } rx_state_t;
  // Crystal divisor giving sixteen times the chosen bit rate
  function automatic logic [10:0] baud_divisor(input logic [2:0] sel);
    case (sel)
      3'h0: baud_divisor = 11'h010;
      3'h1: baud_divisor = 11'h020;
      3'h2: baud_divisor = 11'h040;
      3'h3: baud_divisor = 11'h080;
      3'h4: baud_divisor = 11'h200;
      default: baud_divisor = 11'h574;
    endcase
  endfunction : baud_divisor
endpackage : serial_line_pkg

//--- tb/bus_master_model.sv
// Bus master model driving backplane cycles and acknowledges
`timescale 1ns/1ps
module bus_master_model (
  // Clock
  input wire logic CLK,
  // Backplane, low-active strobes
  output logic SYNC_N,
  output logic DIN_N,
  output logic DOUT_N,
  output logic IO_N,
  output logic ACK_N,
  output logic [15:0] DAL,
  input wire logic REPLY_N,
  input wire logic ACK_OUT_N
);
  initial begin
    SYNC_N = 1'b1;
    DIN_N = 1'b1;
    DOUT_N = 1'b1;
    IO_N = 1'b1;
    ACK_N = 1'b1;
    DAL = 16'h5a5a;
  end
  task automatic step(input int n);
    repeat (n) @(posedge CLK);
    #2;
  endtask : step
  // One bus cycle; ok stays low when no reply comes within the bound
  task automatic cycle(input logic [15:0] adr, input logic wr, input logic io, input logic [15:0] d,
                       output logic ok);
    int n;
    step(1);
    DAL = adr;
    IO_N = !io;
    SYNC_N = 1'b0;
    step(4);
    DAL = wr ? d : ~adr;
    DIN_N = wr;
    DOUT_N = !wr;
    n = 0;
    while (REPLY_N !== 1'b0 && n < 20) begin
      @(posedge CLK);
      n++;
    end
    ok = (n < 20);
    #2;
    DIN_N = 1'b1;
    DOUT_N = 1'b1;
    DAL = ~DAL;
    step(4);
    SYNC_N = 1'b1;
    IO_N = 1'b1;
    step(4);
  endtask : cycle
  // Result: bit 0 vector replied, bit 1 acknowledge passed on
  task automatic ack(output logic [1:0] res);
    int n;
    step(1);
    DIN_N = 1'b0;
    step(1);
    ACK_N = 1'b0;
    n = 0;
    while (REPLY_N !== 1'b0 && ACK_OUT_N !== 1'b0 && n < 20) begin
      @(posedge CLK);
      n++;
    end
    res = {ACK_OUT_N === 1'b0, REPLY_N === 1'b0};
    #2;
    ACK_N = 1'b1;
    DIN_N = 1'b1;
    step(5);
  endtask : ack
endmodule : bus_master_model

//--- tb/tb.sv
// Self-checking bench for the serial line bus interface
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module tb
  import serial_line_pkg::*;
;
  localparam logic [9:0] DEV = 10'h200;
  localparam logic [15:0] VEC = 16'h0040;
  localparam int BIT_CYC = 4167;
  logic clk, rst, sync_n, din_n, dout_n, io_n, ack_n, init_n, si, modem;
  logic oe, reply_n, irq_n, ack_out_n, sout, rrun;
  logic prev_reply = 1'b1;
  logic [15:0] dal, dout, e;
  logic [7:0] b, t;
  logic [1:0] res;
  int n_fail = 0;
  int check_count = 0;
  logic [15:0] exp_q[$];
  bus_master_model mdl (.CLK(clk), .SYNC_N(sync_n), .DIN_N(din_n), .DOUT_N(dout_n), .IO_N(io_n),
    .ACK_N(ack_n), .DAL(dal), .REPLY_N(reply_n), .ACK_OUT_N(ack_out_n));
  serial_line_bus_interface #(.DEV_ADDR(DEV), .VECTOR(VEC), .BAUD_SEL(3'h0)) dut (.CLK(clk), .RST(rst),
    .BUS_SYNC_STROBE_N(sync_n), .BUS_DATA_IN_STROBE_N(din_n), .BUS_DATA_OUT_STROBE_N(dout_n),
    .IO_PAGE_SELECT_N(io_n), .ACK_CHAIN_IN_N(ack_n), .BUS_INITIALIZE_N(init_n),
    .BUS_ADDR_DATA_LINES_IN(dal), .BUS_ADDR_DATA_LINES_OUT(dout), .BUS_ADDR_DATA_LINES_OE(oe),
    .BUS_REPLY_N(reply_n), .BUS_INT_REQUEST_N(irq_n), .ACK_CHAIN_OUT_N(ack_out_n), .SERIAL_IN(si),
    .EXT_RX_CLOCK(1'b0), .MODEM_STATUS(modem), .SERIAL_OUT(sout), .READER_RUN(rrun));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ------------------------------
  // Tasks and result monitor
  // ------------------------------
  task automatic test_done();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  function automatic logic [15:0] adr(input logic [1:0] fn);
    return {3'h0, DEV, fn, 1'b0};
  endfunction : adr
  task automatic rd(input logic [1:0] fn, input logic [15:0] ex);
    logic ok;
    exp_q.push_back(ex);
    mdl.cycle(adr(fn), 1'b0, 1'b1, 16'h0000, ok);
    `CHK(ok, 1'b1)
    if (ok !== 1'b1) test_done();
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic io, input logic [15:0] d, input logic ok_ex);
    logic ok;
    mdl.cycle(a, 1'b1, io, d, ok);
    `CHK(ok, ok_ex)
  endtask : wr
  task automatic send(input logic [7:0] v);
    si = 1'b0;
    tick(1000);
    `CHK(rrun, 1'b1)
    tick(BIT_CYC - 1000);
    `CHK(rrun, 1'b0)
    for (int i = 0; i < 8; i++) begin
      si = v[i];
      tick(BIT_CYC);
    end
    si = 1'b1;
    tick(BIT_CYC * 3 / 2);
  endtask : send
  task automatic catch_tx(input logic [7:0] v);
    int n;
    logic [7:0] got;
    n = 0;
    while (sout !== 1'b0 && n < 2000) begin
      tick(1);
      n++;
    end
    if (n == 2000) n_fail++;
    if (n == 2000) test_done();
    tick(BIT_CYC / 2);
    for (int i = 0; i < 8; i++) begin
      tick(BIT_CYC);
      got[i] = sout;
    end
    tick(BIT_CYC);
    `CHK(sout, 1'b1)
    `CHK(got, v)
  endtask : catch_tx
  // Compares read data and vectors with the oldest note
  always @(posedge clk) begin
    if (reply_n === 1'b0 && prev_reply === 1'b1 && oe === 1'b1) begin
      `CHK(exp_q.size() > 0, 1'b1)
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'h0000;
      `CHK(dout, e)
    end
    prev_reply <= reply_n;
  end
  initial begin
    repeat (98000) @(posedge clk);
    n_fail++;
    test_done();
  end
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    rst = 1'b1;
    init_n = 1'b1;
    si = 1'b1;
    modem = 1'b0;
    void'($urandom(32'hc078));
    repeat (10) @(posedge clk);
    #2;
    rst = 1'b0;
    tick(3);
    rd(FN_RX_STATUS, 16'h0000);
    rd(FN_TX_STATUS, 16'h0080);
    rd(FN_TX_DATA, 16'h0000);
    wr({3'h0, DEV ^ 10'h001, 3'h0}, 1'b1, 16'h0040, 1'b0);
    wr(adr(FN_RX_STATUS), 1'b0, 16'h0040, 1'b0);
    wr(adr(FN_RX_DATA), 1'b1, 16'hffff, 1'b0);
    $display("test decode done");
    b = 8'($urandom);
    modem = 1'($urandom);
    wr(adr(FN_RX_STATUS), 1'b1, 16'h0001, 1'b1);
    send(b);
    rd(FN_RX_STATUS, {modem, 7'h00, 8'h80});
    wr(adr(FN_TX_STATUS), 1'b1, 16'h0040, 1'b1);
    wr(adr(FN_RX_STATUS), 1'b1, 16'h0040, 1'b1);
    `CHK(irq_n, 1'b0)
    exp_q.push_back(VEC);
    mdl.ack(res);
    `CHK(res, 2'h1)
    exp_q.push_back(VEC + VEC_TX_STEP);
    mdl.ack(res);
    `CHK(res, 2'h1)
    `CHK(irq_n, 1'b1)
    mdl.ack(res);
    `CHK(res, 2'h2)
    rd(FN_RX_STATUS, {modem, 7'h00, 8'hc0});
    rd(FN_RX_DATA, {8'h00, b});
    rd(FN_RX_STATUS, {modem, 7'h00, 8'h40});
    $display("test interrupt done");
    t = 8'($urandom);
    wr(adr(FN_TX_DATA), 1'b1, {8'h00, t}, 1'b1);
    catch_tx(t);
    $display("test transmit done");
    wr(adr(FN_TX_STATUS), 1'b1, 16'h0001, 1'b1);
    tick(2000);
    `CHK(sout, 1'b0)
    rd(FN_TX_STATUS, 16'h0081);
    init_n = 1'b0;
    tick(5);
    init_n = 1'b1;
    tick(4);
    `CHK(sout, 1'b1)
    rd(FN_TX_STATUS, 16'h0080);
    rd(FN_RX_STATUS, {modem, 15'h0000});
    rd(FN_RX_DATA, {8'h00, b});
    `CHK(exp_q.size(), 0)
    $display("test initialize done");
    test_done();
  end
endmodule : tb
